/* logic/irc_params.svh */
// register offsets, fields, reset values and counts of the interrupt and reset cause unit
`ifndef IRC_PARAMS_SVH
`define IRC_PARAMS_SVH
`define IRC_NSRC        17
`define IRC_A_CTRL      12'h000
`define IRC_A_ENABLE    12'h004
`define IRC_A_PRIO0     12'h008
`define IRC_A_PRIO1     12'h00c
`define IRC_A_PRIO2     12'h010
`define IRC_A_STATUS    12'h014
`define IRC_A_MASK      12'h018
`define IRC_A_PEND      12'h01c
`define IRC_CAUSE_INDEX 12'h463
`define IRC_A_CAUSE     14'h118c
`define IRC_B_GEN       0
`define IRC_B_CLOCK_OUTPUT_DISABLE      1
`define IRC_B_IM        4
`define IRC_B_WD        2
`define IRC_B_CMD       1
`define IRC_B_EXT       0
`define IRC_CAUSE_RST   8'h01
`define IRC_ST_WAKE     0
`define IRC_ST_IRST     1
`define IRC_EXT0_SRC    5'h00
`define IRC_EXT1_SRC    5'h02
`define IRC_RESP_OK     2'h0
`define IRC_RESP_ERR    2'h2
`endif

/* logic/irc_pkg.sv */
// types of the interrupt and reset cause unit
package irc_pkg;
   typedef enum logic [2:0] {
      IRC_RUN  = 3'b001,
      IRC_IDLE = 3'b010,
      IRC_DOWN = 3'b100
   } irc_pwr_e;
   typedef logic [2:0] irc_prio_t;
endpackage : irc_pkg

/* logic/irc_unit.sv */
// interrupt arbiter, power mode and reset cause logic with axi4-lite registers
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "irc_params.svh"
module irc_unit
   import irc_pkg::*;
#(
   parameter int NSRC = `IRC_NSRC
)(
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic [NSRC-1:0]   event_req,
   input  wire logic              ext_reset_n,
   input  wire logic              watchdog_reset,
   input  wire logic              reset_instr,
   input  wire logic              idle_req,
   input  wire logic              power_down_req,
   input  wire logic              ext_access_strap,
   input  wire logic              bus_width_strap,
   output logic                   core_irq_req,
   output logic [4:0]             core_irq_src,
   output logic [3:0]             core_irq_prio,
   output logic                   core_reset,
   output logic                   osc_stop,
   output logic                   idle_mode,
   output logic                   ext_access_latch,
   output logic                   bus_width_latch,
   output logic                   reset_indication_out,
   output logic                   reset_indication_oe,
   output logic                   bus_clock_output,
   output logic                   irq,
   input  wire logic [13:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [13:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   // the arbiter serves exactly seventeen event sources
   if (NSRC != `IRC_NSRC)
   begin : g_bad_nsrc
      $error("irc_unit: source count must be 17");
   end

   // ----------------------------------------
   // reset pin sync and reset cause
   // ----------------------------------------
   logic [2:0] pin_sync;
   logic       pin_low;
   logic [7:0] reset_cause;
   logic       reset_event;
   logic       next_pin_low;
   logic [7:0] next_cause;
   logic       next_oe;
   logic       next_ea;
   logic       next_bw;

   // a pin change counts only once the second and third stages agree
   always_comb
   begin
      next_pin_low = (pin_sync[1] == pin_sync[2]) ? ~pin_sync[2] : pin_low;
      next_cause   = reset_cause;
      next_ea      = ext_access_latch;
      next_bw      = bus_width_latch;
      if (next_pin_low)
         next_cause = 8'h01 << `IRC_B_EXT;
      else if (watchdog_reset)
         next_cause = 8'h01 << `IRC_B_WD;
      else if (reset_instr)
         next_cause = 8'h01 << `IRC_B_CMD;
      // straps follow the pin reset only
      if (next_pin_low)
      begin
         next_ea = ext_access_strap;
         next_bw = bus_width_strap;
      end
      next_oe = next_pin_low | watchdog_reset | reset_instr;
   end

   always_ff @(posedge clk_sys)
   begin
      pin_sync <= {pin_sync[1:0], ext_reset_n};
      if (sys_rst)
      begin
         pin_low             <= 1'b0;
         reset_cause         <= `IRC_CAUSE_RST;
         reset_indication_oe <= 1'b0;
         ext_access_latch    <= 1'b0;
         bus_width_latch     <= 1'b0;
      end
      else
      begin
         pin_low             <= next_pin_low;
         reset_cause         <= next_cause;
         reset_indication_oe <= next_oe;
         ext_access_latch    <= next_ea;
         bus_width_latch     <= next_bw;
      end
   end

   // any reset clears the core ahead of every event
   assign reset_event          = pin_low | watchdog_reset | reset_instr;
   assign core_reset           = reset_indication_oe;
   assign reset_indication_out = 1'b0;

   // ----------------------------------------
   // registers and axi4-lite slave
   // ----------------------------------------
   logic            glob_en;
   logic            clock_output_disable;
   logic [3:0]      exec_mask;
   logic [NSRC-1:0] enable;
   irc_prio_t       prio [NSRC];
   logic [1:0]      status;
   logic [1:0]      mask;
   logic            aw_got, w_got;
   logic [13:0]     aw_addr;
   logic [31:0]     w_data;
   logic [3:0]      w_strb;
   logic            next_glob_en, next_clock_output_disable;
   logic [3:0]      next_exec_mask;
   logic [NSRC-1:0] next_enable;
   irc_prio_t       next_prio [NSRC];
   logic [1:0]      next_status, next_mask;
   logic            next_aw_got, next_w_got, next_bvalid, next_rvalid;
   logic [13:0]     next_aw_addr;
   logic [31:0]     next_w_data, next_rdata, wm, cur, nw;
   logic [3:0]      next_w_strb;
   logic [1:0]      next_bresp, next_rresp;
   logic            wr_go, rd_go, hit;
   logic [1:0]      ev;
   logic            pwr_wake;

   assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_got & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_go         = aw_got & w_got & ~s_axi_bvalid;
   assign rd_go         = s_axi_arvalid & s_axi_arready;
   assign ev            = {reset_event, pwr_wake};
   assign irq           = |(status & mask);

   always_comb
   begin
      next_glob_en   = glob_en;
      next_clock_output_disable      = clock_output_disable;
      next_exec_mask = exec_mask;
      next_enable    = enable;
      next_prio      = prio;
      next_status    = status;
      next_mask      = mask;
      next_aw_got    = aw_got | (s_axi_awvalid & s_axi_awready);
      next_w_got     = w_got | (s_axi_wvalid & s_axi_wready);
      next_aw_addr   = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : aw_addr;
      next_w_data    = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : w_data;
      next_w_strb    = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : w_strb;
      next_bvalid    = s_axi_bvalid & ~s_axi_bready;
      next_bresp     = s_axi_bresp;
      next_rvalid    = s_axi_rvalid & ~s_axi_rready;
      next_rdata     = s_axi_rdata;
      next_rresp     = s_axi_rresp;
      wm  = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
      cur = 32'h0;
      hit = 1'b1;
      unique case (aw_addr[11:0])
         `IRC_A_CTRL:   cur = {24'h0, exec_mask, 2'h0, clock_output_disable, glob_en};
         `IRC_A_ENABLE: cur = {15'h0, enable};
         `IRC_A_MASK:   cur = {30'h0, mask};
         default:       cur = 32'h0;
      endcase
      for (int i = 0; i < NSRC; i++)
         if (aw_addr[11:0] == `IRC_A_PRIO0 + 12'((i / 8) * 4))
            cur[4*(i%8)+:3] = prio[i];
      nw = (cur & ~wm) | (w_data & wm);
      if (wr_go)
      begin
         next_aw_got = 1'b0;
         next_w_got  = 1'b0;
         next_bvalid = 1'b1;
         if (aw_addr[13:12] != 2'h0)
            hit = 1'b0;
         else if (aw_addr[11:0] == `IRC_A_CTRL)
         begin
            next_glob_en   = nw[`IRC_B_GEN];
            next_clock_output_disable      = nw[`IRC_B_CLOCK_OUTPUT_DISABLE];
            next_exec_mask = nw[`IRC_B_IM+:4];
         end
         else if (aw_addr[11:0] == `IRC_A_ENABLE)
            next_enable = nw[NSRC-1:0];
         else if (aw_addr[11:0] == `IRC_A_MASK)
            next_mask = nw[1:0];
         else if (aw_addr[11:0] >= `IRC_A_PRIO0 && aw_addr[11:0] <= `IRC_A_PRIO2 && aw_addr[1:0] == 2'h0)
         begin
            for (int i = 0; i < NSRC; i++)
               if (aw_addr[11:0] == `IRC_A_PRIO0 + 12'((i / 8) * 4))
                  next_prio[i] = nw[4*(i%8)+:3];
         end
         else
            hit = 1'b0;
         next_bresp = hit ? `IRC_RESP_OK : `IRC_RESP_ERR;
      end
      if (rd_go)
      begin
         next_rvalid = 1'b1;
         next_rresp  = `IRC_RESP_OK;
         next_rdata  = 32'h0;
         if (s_axi_araddr == `IRC_A_CAUSE)
            next_rdata = {24'h0, reset_cause};
         else if (s_axi_araddr[13:12] != 2'h0)
            next_rresp = `IRC_RESP_ERR;
         else
            unique case (s_axi_araddr[11:0])
               `IRC_A_CTRL:   next_rdata = {24'h0, exec_mask, 2'h0, clock_output_disable, glob_en};
               `IRC_A_ENABLE: next_rdata = {15'h0, enable};
               `IRC_A_MASK:   next_rdata = {30'h0, mask};
               `IRC_A_STATUS:
               begin
                  next_rdata  = {30'h0, status};
                  next_status = 2'h0;
               end
               `IRC_A_PEND:
                  next_rdata = {14'h0, osc_stop, idle_mode, core_irq_prio,
                                3'h0, core_irq_req, 3'h0, core_irq_src};
               `IRC_A_PRIO0, `IRC_A_PRIO1, `IRC_A_PRIO2:
                  for (int i = 0; i < NSRC; i++)
                     if (s_axi_araddr[11:0] == `IRC_A_PRIO0 + 12'((i / 8) * 4))
                        next_rdata[4*(i%8)+:3] = prio[i];
               default: next_rresp = `IRC_RESP_ERR;
            endcase
      end
      // set wins over the clear of a status read
      next_status = next_status | ev;
      // internal resets restore control, but status and mask survive for software
      if (reset_event)
      begin
         next_glob_en   = 1'b0;
         next_clock_output_disable      = 1'b0;
         next_exec_mask = 4'h0;
         next_enable    = '0;
         for (int i = 0; i < NSRC; i++)
            next_prio[i] = 3'h0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         glob_en      <= 1'b0;
         clock_output_disable         <= 1'b0;
         exec_mask    <= 4'h0;
         enable       <= '0;
         for (int i = 0; i < NSRC; i++)
            prio[i] <= 3'h0;
         status       <= 2'h0;
         mask         <= 2'h0;
         aw_got       <= 1'b0;
         w_got        <= 1'b0;
         aw_addr      <= 14'h0;
         w_data       <= 32'h0;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= 2'h0;
      end
      else
      begin
         glob_en      <= next_glob_en;
         clock_output_disable         <= next_clock_output_disable;
         exec_mask    <= next_exec_mask;
         enable       <= next_enable;
         prio         <= next_prio;
         status       <= next_status;
         mask         <= next_mask;
         aw_got       <= next_aw_got;
         w_got        <= next_w_got;
         aw_addr      <= next_aw_addr;
         w_data       <= next_w_data;
         w_strb       <= next_w_strb;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp  <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rresp;
      end
   end

   // ----------------------------------------
   // arbitration, power modes, clock output
   // ----------------------------------------
   irc_pwr_e   pwr, next_pwr;
   logic       win_v, next_req, clk_en, next_clk_en;
   logic [4:0] win_i;
   logic [3:0] win_p, eff;

   always_comb
   begin
      win_v    = 1'b0;
      win_i    = 5'h0;
      // start at the mask so only strictly higher wins
      win_p    = exec_mask;
      pwr_wake = 1'b0;
      eff      = 4'h0;
      // counter array sources ride in the same event set
      for (int i = 0; i < NSRC; i++)
      begin
         eff = (prio[i] == 3'h0) ? 4'h0 : {1'b1, prio[i]};
         // strict compare keeps the lower ranked index on ties
         if (glob_en && enable[i] && event_req[i] && eff > win_p)
         begin
            win_v = 1'b1;
            win_i = 5'(i);
            win_p = eff;
         end
         if ((5'(i) == `IRC_EXT0_SRC || 5'(i) == `IRC_EXT1_SRC) && glob_en && enable[i]
             && event_req[i] && eff > exec_mask && pwr == IRC_DOWN)
            pwr_wake = 1'b1;
      end
      // power-down halts, idle resumes on any taken request
      next_pwr = pwr;
      unique case (pwr)
         IRC_RUN:
            if (power_down_req)
               next_pwr = IRC_DOWN;
            else if (idle_req)
               next_pwr = IRC_IDLE;
         IRC_IDLE:
            if (win_v)
               next_pwr = IRC_RUN;
         IRC_DOWN:
            if (pwr_wake)
               next_pwr = IRC_RUN;
         default: next_pwr = IRC_RUN;
      endcase
      next_req = win_v & ~reset_event & (pwr != IRC_DOWN);
      if (reset_event)
         next_pwr = IRC_RUN;
      // clock output on unless disabled or oscillator stopped
      next_clk_en = ~next_clock_output_disable & (next_pwr != IRC_DOWN);
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         pwr           <= IRC_RUN;
         core_irq_req  <= 1'b0;
         core_irq_src  <= 5'h0;
         core_irq_prio <= 4'h0;
         clk_en        <= 1'b1;
      end
      else
      begin
         pwr           <= next_pwr;
         core_irq_req  <= next_req;
         core_irq_src  <= win_i;
         core_irq_prio <= next_req ? win_p : 4'h0;
         clk_en        <= next_clk_en;
      end
   end

   // gating on an enable registered at the rising edge, so the enable changes while the clock is high
   assign bus_clock_output = clk_sys & clk_en;
   assign osc_stop         = (pwr == IRC_DOWN);
   assign idle_mode        = (pwr == IRC_IDLE);

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence wd_hit;
      watchdog_reset && !next_pin_low;
   endsequence

   grant_enable_a: assert property (core_irq_req |-> $past(glob_en))
      else $error("request without global enable");
   prio_nonzero_a: assert property (core_irq_req |-> core_irq_prio[3])
      else $error("zero priority source taken");
   prio_map_a: assert property (core_irq_req |-> core_irq_prio == {1'b1, $past(prio[win_i])})
      else $error("effective priority mapping wrong");
   mask_strict_a: assert property (core_irq_req |-> core_irq_prio > $past(exec_mask))
      else $error("request not above mask");
   cause_wd_a: assert property (wd_hit |=> reset_cause == 8'h04)
      else $error("watchdog cause not sole bit");
   rst_ind_a: assert property (reset_instr |=> reset_indication_oe ##1 !core_irq_req)
      else $error("reset indication missed");
   pd_exit_a: assert property (pwr == IRC_DOWN && reset_event |=> pwr == IRC_RUN)
      else $error("power-down not left on reset");
   clk_off_a: assert property (clock_output_disable |-> !clk_en)
      else $error("clock output not disabled");
   strap_hold_a: assert property (!next_pin_low && (watchdog_reset || reset_instr)
                                  |=> $stable(ext_access_latch) && $stable(bus_width_latch))
      else $error("straps relatched on internal reset");
endmodule : irc_unit

/* tb/irc_core_model.sv */
// partner model: processor core and peripheral event sources
`timescale 1ns/1ps
module irc_core_model
#(
   parameter int NSRC = 17
)(
   input  wire logic              clk_sys,
   output logic [NSRC-1:0]        event_req,
   output logic                   ext_reset_n,
   output logic                   watchdog_reset,
   output logic                   reset_instr,
   output logic                   idle_req,
   output logic                   power_down_req,
   output logic                   ext_access_strap,
   output logic                   bus_width_strap
);
   // pin held low past the bus reset so the unit sees a pin reset event
   initial
   begin
      event_req        = '0;
      ext_reset_n      = 1'b0;
      watchdog_reset   = 1'b0;
      reset_instr      = 1'b0;
      idle_req         = 1'b0;
      power_down_req   = 1'b0;
      ext_access_strap = 1'b1;
      bus_width_strap  = 1'b0;
      repeat (25) @(posedge clk_sys);
      ext_reset_n <= 1'b1;
   end

   // levels from peripherals, held until changed
   task set_ev(input logic [NSRC-1:0] v);
      event_req <= v;
   endtask : set_ev

   // one-cycle pulses: 0 watchdog, 1 reset instruction, 2 idle, 3 power-down
   task pulse(input int k);
      case (k)
         0: watchdog_reset <= 1'b1;
         1: reset_instr <= 1'b1;
         2: idle_req <= 1'b1;
         default: power_down_req <= 1'b1;
      endcase
      @(posedge clk_sys);
      watchdog_reset <= 1'b0;
      reset_instr    <= 1'b0;
      idle_req       <= 1'b0;
      power_down_req <= 1'b0;
   endtask : pulse

   // strap levels only matter while the pin reset is low
   task set_straps(input logic ea, input logic bw);
      ext_access_strap <= ea;
      bus_width_strap  <= bw;
   endtask : set_straps

   // pin low long enough to clear the three-flop synchroniser
   task pin_reset(input logic ea, input logic bw);
      ext_reset_n      <= 1'b0;
      ext_access_strap <= ea;
      bus_width_strap  <= bw;
      repeat (8) @(posedge clk_sys);
      ext_reset_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
   endtask : pin_reset
endmodule : irc_core_model

/* tb/tb_irc_unit.sv */
// self-checking bench of the interrupt and reset cause unit
`timescale 1ns/1ps
`include "irc_params.svh"
module tb_irc_unit;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic [16:0] event_req;
   logic        ext_reset_n, watchdog_reset, reset_instr, idle_req, power_down_req;
   logic        ext_access_strap, bus_width_strap, core_irq_req, core_reset, osc_stop, idle_mode;
   logic        ext_access_latch, bus_width_latch, reset_indication_out, reset_indication_oe;
   logic        bus_clock_output, irq;
   logic [4:0]  core_irq_src;
   logic [3:0]  core_irq_prio;
   logic [13:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int          error_cnt = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          n;
   int          srcs[7] = '{5, 11, 12, 13, 14, 15, 16};
   // open-drain pin with a pull-up
   wire         rst_pin = reset_indication_oe ? reset_indication_out : 1'b1;

   irc_unit i_dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .event_req(event_req), .ext_reset_n(ext_reset_n),
      .watchdog_reset(watchdog_reset), .reset_instr(reset_instr), .idle_req(idle_req),
      .power_down_req(power_down_req), .ext_access_strap(ext_access_strap), .bus_width_strap(bus_width_strap),
      .core_irq_req(core_irq_req), .core_irq_src(core_irq_src), .core_irq_prio(core_irq_prio),
      .core_reset(core_reset), .osc_stop(osc_stop), .idle_mode(idle_mode), .ext_access_latch(ext_access_latch),
      .bus_width_latch(bus_width_latch), .reset_indication_out(reset_indication_out),
      .reset_indication_oe(reset_indication_oe), .bus_clock_output(bus_clock_output), .irq(irq),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   irc_core_model i_core (
      .clk_sys(clk_sys), .event_req(event_req), .ext_reset_n(ext_reset_n), .watchdog_reset(watchdog_reset),
      .reset_instr(reset_instr), .idle_req(idle_req), .power_down_req(power_down_req),
      .ext_access_strap(ext_access_strap), .bus_width_strap(bus_width_strap));

   always #10 clk_sys = ~clk_sys;

   // hang guard, well above the expected few hundred cycles
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         error_cnt++;
         wrap_up();
      end
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // handshakes judged at the falling edge, taken at the next rising edge
   task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
      logic       aw, w, b;
      logic [1:0] r;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      b = 1'b0;
      while (!b)
      begin
         @(negedge clk_sys);
         aw = s_axi_awvalid & s_axi_awready;
         w = s_axi_wvalid & s_axi_wready;
         b = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clk_sys);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
      chk(b, 1'b1);
      chk(r, er);
   endtask : wr

   task automatic rd(input logic [13:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic        ar, v;
      logic [31:0] d;
      logic [1:0]  r;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      v = 1'b0;
      while (!v)
      begin
         @(negedge clk_sys);
         ar = s_axi_arvalid & s_axi_arready;
         v = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk_sys);
         if (ar) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
      chk(v, 1'b1);
      chk(d, ed);
      chk(r, er);
   endtask : rd

   // request outputs settle one edge after their causes; three allow margin
   task automatic core(input logic rq, input logic [4:0] s, input logic [3:0] p);
      repeat (3) @(negedge clk_sys);
      chk(core_irq_req, rq);
      if (rq) chk(core_irq_src, s);
      chk(core_irq_prio, rq ? p : 4'h0);
      @(posedge clk_sys);
   endtask : core

   task automatic wait_low(ref logic s);
      for (int i = 0; i < 20 && s !== 1'b0; i++) @(negedge clk_sys);
      chk(s, 1'b0);
      @(posedge clk_sys);
   endtask : wait_low

   task automatic bco(input logic e);
      @(posedge clk_sys);
      #5;
      chk(bus_clock_output, e);
      @(posedge clk_sys);
   endtask : bco

   task wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      s_axi_awaddr  = '0;
      s_axi_araddr  = '0;
      s_axi_wdata   = '0;
      s_axi_wstrb   = 4'hf;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid  = 1'b0;
      s_axi_bready  = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready  = 1'b0;
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (20) @(posedge clk_sys);
      rd(`IRC_A_CAUSE, 32'h01, `IRC_RESP_OK);
      rd(`IRC_A_STATUS, 32'h02, `IRC_RESP_OK);
      chk(ext_access_latch, 1'b1);
      bco(1'b1);
      wr(`IRC_A_CTRL, 32'h2, `IRC_RESP_OK);
      bco(1'b0);
      wr(`IRC_A_ENABLE, 32'h1ffff, `IRC_RESP_OK);
      rd(`IRC_A_ENABLE, 32'h1ffff, `IRC_RESP_OK);
      wr(14'h020, 32'h1, `IRC_RESP_ERR);
      rd(14'h020, 32'h0, `IRC_RESP_ERR);
      wr(`IRC_A_CAUSE, 32'h0, `IRC_RESP_ERR);
      rd(`IRC_A_CAUSE, 32'h01, `IRC_RESP_OK);
      // ties, zero field and enables
      wr(`IRC_A_CTRL, 32'h1, `IRC_RESP_OK);
      wr(`IRC_A_PRIO0, 32'h20002000, `IRC_RESP_OK);
      i_core.set_ev(17'h0008a);
      core(1'b1, 5'h03, 4'ha);
      wr(`IRC_A_ENABLE, 32'h1fff7, `IRC_RESP_OK);
      core(1'b1, 5'h07, 4'ha);
      wr(`IRC_A_CTRL, 32'h0, `IRC_RESP_OK);
      core(1'b0, 5'h00, 4'h0);
      wr(`IRC_A_CTRL, 32'ha1, `IRC_RESP_OK);
      core(1'b0, 5'h00, 4'h0);
      wr(`IRC_A_CTRL, 32'h91, `IRC_RESP_OK);
      core(1'b1, 5'h07, 4'ha);
      rd(`IRC_A_PEND, 32'h0000a107, `IRC_RESP_OK);
      // every nonzero field value
      wr(`IRC_A_CTRL, 32'h1, `IRC_RESP_OK);
      i_core.set_ev(17'h00001);
      for (n = 1; n < 8; n++)
      begin
         wr(`IRC_A_PRIO0, 32'(n), `IRC_RESP_OK);
         core(1'b1, 5'h00, 4'(8 + n));
      end
      // upper sources, counter array group included
      wr(`IRC_A_ENABLE, 32'h1ffff, `IRC_RESP_OK);
      wr(`IRC_A_PRIO0, 32'h11111111, `IRC_RESP_OK);
      wr(`IRC_A_PRIO1, 32'h11111111, `IRC_RESP_OK);
      wr(`IRC_A_PRIO2, 32'h1, `IRC_RESP_OK);
      foreach (srcs[k])
      begin
         i_core.set_ev(17'h1 << srcs[k]);
         core(1'b1, 5'(srcs[k]), 4'h9);
      end
      // byte strobes: only lane 0 is written
      s_axi_wstrb <= 4'h1;
      wr(`IRC_A_ENABLE, 32'h0, `IRC_RESP_OK);
      s_axi_wstrb <= 4'hf;
      rd(`IRC_A_ENABLE, 32'h1ff00, `IRC_RESP_OK);
      // power-down: only an external source wakes it
      i_core.set_ev(17'h0);
      wr(`IRC_A_ENABLE, 32'h9, `IRC_RESP_OK);
      wr(`IRC_A_PRIO0, 32'h3001, `IRC_RESP_OK);
      i_core.pulse(3);
      i_core.set_ev(17'h00008);
      core(1'b0, 5'h00, 4'h0);
      chk(osc_stop, 1'b1);
      i_core.set_ev(17'h00009);
      wait_low(osc_stop);
      core(1'b1, 5'h03, 4'hb);
      rd(`IRC_A_STATUS, 32'h01, `IRC_RESP_OK);
      // idle: any winning request ends it
      i_core.set_ev(17'h0);
      i_core.pulse(2);
      core(1'b0, 5'h00, 4'h0);
      chk(idle_mode, 1'b1);
      i_core.set_ev(17'h00008);
      wait_low(idle_mode);
      // a watchdog reset keeps the straps and the mask, a pin reset relatches the straps
      i_core.set_ev(17'h0);
      wr(`IRC_A_MASK, 32'h2, `IRC_RESP_OK);
      i_core.set_straps(1'b0, 1'b1);
      i_core.pulse(0);
      @(negedge clk_sys);
      chk(rst_pin, 1'b0);
      chk(core_reset, 1'b1);
      @(negedge clk_sys);
      chk(rst_pin, 1'b1);
      @(posedge clk_sys);
      rd(`IRC_A_CAUSE, 32'h04, `IRC_RESP_OK);
      chk(irq, 1'b1);
      rd(`IRC_A_STATUS, 32'h02, `IRC_RESP_OK);
      chk(irq, 1'b0);
      rd(`IRC_A_CTRL, 32'h0, `IRC_RESP_OK);
      chk(ext_access_latch, 1'b1);
      i_core.pulse(1);
      rd(`IRC_A_CAUSE, 32'h02, `IRC_RESP_OK);
      i_core.pin_reset(1'b0, 1'b1);
      rd(`IRC_A_CAUSE, 32'h01, `IRC_RESP_OK);
      chk(ext_access_latch, 1'b0);
      chk(bus_width_latch, 1'b1);
      wrap_up();
   end
endmodule : tb_irc_unit
